//--- rtl/pcfg_cfg.svh
//
// Behaviour
// - Reload select steers byte addresses to reload
// - Reload values used only in 9-11 bit PWM
// - Overflow enable gates flag onto shared interrupt
// - Flag set on overflow of selected bit
// - Hardware or software sets flag; software clears
// - Bits 4:2 read zero, writes ignored
// - Length field codes: 00=8, 01=9, 10=10, 11=11
// - Length applies to all non-wide PWM channels
// - Per-channel wide enable bypasses shared length
`ifndef PCFG_CFG_SVH
`define PCFG_CFG_SVH

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define PCFG_OFF_CONFIG 8'h00
`define PCFG_OFF_STATUS 8'h04
`define PCFG_OFF_MASK 8'h08
`define PCFG_OFF_COUNT 8'h0c
`define PCFG_OFF_CC_BASE 8'h10
`define PCFG_CC_STRIDE 8'h08
`define PCFG_OFF_MODE_BASE 8'h40
`define PCFG_MODE_STRIDE 8'h04
`define PCFG_CH_COUNT 6

// ****************************************************************
// Field positions
// ****************************************************************
`define PCFG_BIT_RSEL 7
`define PCFG_BIT_IRQEN 6
`define PCFG_BIT_FLAG 5
`define PCFG_BIT_LEN_HI 1
`define PCFG_BIT_LEN_LO 0
`define PCFG_BIT_WIDE 7
`define PCFG_BIT_PWMEN 1
`define PCFG_EVT_OVF 0
`define PCFG_EVT_RELOAD 1
`define PCFG_EVT_W 2

// ****************************************************************
// Reset values and overflow masks
// ****************************************************************
`define PCFG_CONFIG_RST 8'h00
`define PCFG_WORD_RST 16'h0000
`define PCFG_EVT_RST 2'h0
`define PCFG_MASK_8 11'h0ff
`define PCFG_MASK_9 11'h1ff
`define PCFG_MASK_10 11'h3ff
`define PCFG_MASK_11 11'h7ff

`endif

//--- rtl/pcfg_pkg.sv
package pcfg_pkg;

  // Cycle length codes
  typedef enum logic [1:0] {
    LEN8 = 2'b00,
    LEN9 = 2'b01,
    LEN10 = 2'b10,
    LEN11 = 2'b11
  } pcfg_len_type;

  // Configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic reloadRegSelect;
    logic cycleOvfIrqEn;
    logic cycleOvfFlag;
    logic [2:0] unused;
    pcfg_len_type cycleLengthSel;
  } pcfg_config_type;

  // Per-channel mode bits that this block uses
  typedef struct packed {
    logic widePwmEn;
    logic pwmEn;
  } pcfg_mode_type;

endpackage

//--- rtl/pcfg_reload_bank.sv
`timescale 1ns/1ps
`include "pcfg_cfg.svh"
module pcfg_reload_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Byte write port
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic wrHigh,
  input wire logic [7:0] wrData,
  // Byte read port
  input wire logic [2:0] rdIdx,
  input wire logic rdHigh,
  output logic [7:0] rdByte,
  // Whole reload words
  output logic [`PCFG_CH_COUNT-1:0][15:0] reloadWord
);

  // Shadow reload words, one per channel
  logic [15:0] mem_q [`PCFG_CH_COUNT];

  // Byte writes from the bus only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PCFG_CH_COUNT; i++) begin
        mem_q[i] <= `PCFG_WORD_RST;
      end
    end else if (wrEn && (wrIdx < 3'(`PCFG_CH_COUNT))) begin
      if (wrHigh) begin
        mem_q[wrIdx][15:8] <= wrData;
      end else begin
        mem_q[wrIdx][7:0] <= wrData;
      end
    end
  end

  // Byte read, out of range reads zero
  always_comb begin
    rdByte = 8'h00;
    if (rdIdx < 3'(`PCFG_CH_COUNT)) begin
      rdByte = rdHigh ? mem_q[rdIdx][15:8] : mem_q[rdIdx][7:0];
    end
  end

  // Words for the reload path
  genvar g;
  generate
    for (g = 0; g < `PCFG_CH_COUNT; g++) begin : gWord
      assign reloadWord[g] = mem_q[g];
    end
  endgenerate

endmodule

//--- rtl/pcfg_top.sv
`timescale 1ns/1ps
`include "pcfg_cfg.svh"
module pcfg_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Main counter, same clock
  input wire logic [15:0] counterValue,
  input wire logic counterTick,
  // Channel outputs
  output logic [`PCFG_CH_COUNT-1:0][15:0] ccValue,
  output pcfg_pkg::pcfg_mode_type [`PCFG_CH_COUNT-1:0] chMode,
  output pcfg_pkg::pcfg_len_type cycleLen,
  output logic irq
);

  localparam int CH = `PCFG_CH_COUNT;

  // ****************************************************************
  // Bus handshake and decode
  // ****************************************************************
  logic waitReq_q;
  logic [31:0] readData_q;
  logic accept;
  logic wrByte;
  logic [7:0] ccOff;
  logic [7:0] modeOff;
  logic ccHit;
  logic modeHit;
  logic [2:0] ccIdx;
  logic ccHigh;
  logic [2:0] modeIdx;
  logic wrCfg;
  logic wrStatus;
  logic wrMask;
  logic wrCcAny;
  logic wrReload;
  logic [31:0] rdData;

  // Request is taken at the edge where waitrequest is seen low
  assign accept = (read || write) && !waitReq_q;
  assign wrByte = accept && write && byteenable[0];
  assign ccOff = address - `PCFG_OFF_CC_BASE;
  assign modeOff = address - `PCFG_OFF_MODE_BASE;
  assign ccHit = (address >= `PCFG_OFF_CC_BASE) &&
    (ccOff < 8'(CH * 8)) && (address[1:0] == 2'b00);
  assign modeHit = (address >= `PCFG_OFF_MODE_BASE) &&
    (modeOff < 8'(CH * 4)) && (address[1:0] == 2'b00);
  assign ccIdx = ccOff[5:3];
  assign ccHigh = ccOff[2];
  assign modeIdx = modeOff[4:2];
  assign wrCfg = wrByte && (address == `PCFG_OFF_CONFIG);
  assign wrStatus = wrByte && (address == `PCFG_OFF_STATUS);
  assign wrMask = wrByte && (address == `PCFG_OFF_MASK);
  assign wrCcAny = wrByte && ccHit;

  // One wait cycle per access; data is ready when waitrequest drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitReq_q <= 1'b1;
    end else if ((read || write) && waitReq_q) begin
      waitReq_q <= 1'b0;
    end else begin
      waitReq_q <= 1'b1;
    end
  end

  // Read data captured while the master holds the request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readData_q <= 32'h0000_0000;
    end else if (read && waitReq_q) begin
      readData_q <= rdData;
    end
  end

  assign waitrequest = waitReq_q;
  assign readdata = readData_q;

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  pcfg_pkg::pcfg_config_type cfg_q;
  logic ovfPulse;

  // Plain fields; unused bits never store a one. The flag lives
  // here too, so the whole register has a single writer; a
  // hardware set beats a software clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= pcfg_pkg::pcfg_config_type'(`PCFG_CONFIG_RST);
    end else begin
      if (wrCfg) begin
        cfg_q.reloadRegSelect <= writedata[`PCFG_BIT_RSEL];
        cfg_q.cycleOvfIrqEn <= writedata[`PCFG_BIT_IRQEN];
        cfg_q.unused <= 3'h0;
        cfg_q.cycleLengthSel <= pcfg_pkg::pcfg_len_type'(
          writedata[`PCFG_BIT_LEN_HI:`PCFG_BIT_LEN_LO]);
      end
      if (ovfPulse) begin
        cfg_q.cycleOvfFlag <= 1'b1;
      end else if (wrCfg) begin
        cfg_q.cycleOvfFlag <= writedata[`PCFG_BIT_FLAG];
      end
    end
  end

  assign cycleLen = cfg_q.cycleLengthSel;

  // ****************************************************************
  // Cycle overflow detection
  // ****************************************************************
  logic [10:0] lenMask;

  // Overflow bit follows the selected length
  always_comb begin
    case (cfg_q.cycleLengthSel)
      pcfg_pkg::LEN8: lenMask = `PCFG_MASK_8;
      pcfg_pkg::LEN9: lenMask = `PCFG_MASK_9;
      pcfg_pkg::LEN10: lenMask = `PCFG_MASK_10;
      pcfg_pkg::LEN11: lenMask = `PCFG_MASK_11;
      default: lenMask = `PCFG_MASK_8;
    endcase
  end

  // Tick from all ones in the low bits carries out of the top bit
  assign ovfPulse = counterTick &&
    ((counterValue[10:0] & lenMask) == lenMask);

  // ****************************************************************
  // Channel modes and auto-reload shadow words
  // ****************************************************************
  logic [CH-1:0][15:0] reloadWord;
  logic [CH-1:0] reloadUse;
  logic [7:0] reloadRd;
  pcfg_pkg::pcfg_mode_type [CH-1:0] mode_q;

  // Same byte addresses reach the shadow words when selected
  assign wrReload = wrCcAny && cfg_q.reloadRegSelect;

  pcfg_reload_bank uReload (
    .mclk(mclk),
    .rst(rst),
    .wrEn(wrReload),
    .wrIdx(ccIdx),
    .wrHigh(ccHigh),
    .wrData(writedata[7:0]),
    .rdIdx(ccIdx),
    .rdHigh(ccHigh),
    .rdByte(reloadRd),
    .reloadWord(reloadWord)
  );

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : gChan
      // Mode bits per channel
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          mode_q[g] <= '0;
        end else if (wrByte && modeHit && modeIdx == 3'(g)) begin
          mode_q[g].widePwmEn <= writedata[`PCFG_BIT_WIDE];
          mode_q[g].pwmEn <= writedata[`PCFG_BIT_PWMEN];
        end
      end

      // Wide channels and 8-bit cycles never load the shadow word
      assign reloadUse[g] = mode_q[g].pwmEn && !mode_q[g].widePwmEn &&
        (cfg_q.cycleLengthSel != pcfg_pkg::LEN8);

      // Compare word; a bus write wins over a reload in one cycle
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          ccValue[g] <= `PCFG_WORD_RST;
        end else if (wrCcAny && !cfg_q.reloadRegSelect &&
                     ccIdx == 3'(g)) begin
          if (ccHigh) begin
            ccValue[g][15:8] <= writedata[7:0];
          end else begin
            ccValue[g][7:0] <= writedata[7:0];
          end
        end else if (ovfPulse && reloadUse[g]) begin
          ccValue[g] <= reloadWord[g];
        end
      end
    end
  endgenerate

  assign chMode = mode_q;

  // ****************************************************************
  // Event status, mask and interrupt
  // ****************************************************************
  logic [`PCFG_EVT_W-1:0] status_q;
  logic [`PCFG_EVT_W-1:0] mask_q;
  logic [`PCFG_EVT_W-1:0] evtSet;
  logic [`PCFG_EVT_W-1:0] evtClr;
  logic irq_q;

  assign evtSet = {ovfPulse && (|reloadUse), ovfPulse};
  assign evtClr = wrStatus ? writedata[`PCFG_EVT_W-1:0] :
    `PCFG_EVT_RST;

  // Sticky, write one to clear, new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= `PCFG_EVT_RST;
    end else begin
      status_q <= (status_q & ~evtClr) | evtSet;
    end
  end

  // Mask register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_q <= `PCFG_EVT_RST;
    end else if (wrMask) begin
      mask_q <= writedata[`PCFG_EVT_W-1:0];
    end
  end

  // Registered for a clean pin; lags the flags by one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(status_q & mask_q)) ||
        (cfg_q.cycleOvfFlag && cfg_q.cycleOvfIrqEn);
    end
  end

  assign irq = irq_q;

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb begin
    rdData = 32'h0000_0000;
    if (address == `PCFG_OFF_CONFIG) begin
      rdData[7:0] = cfg_q;
    end else if (address == `PCFG_OFF_STATUS) begin
      rdData[`PCFG_EVT_W-1:0] = status_q;
    end else if (address == `PCFG_OFF_MASK) begin
      rdData[`PCFG_EVT_W-1:0] = mask_q;
    end else if (address == `PCFG_OFF_COUNT) begin
      rdData[15:0] = counterValue;
    end else if (ccHit && cfg_q.reloadRegSelect) begin
      rdData[7:0] = reloadRd;
    end else if (ccHit) begin
      rdData[7:0] = ccHigh ? ccValue[ccIdx][15:8] : ccValue[ccIdx][7:0];
    end else if (modeHit) begin
      rdData[`PCFG_BIT_WIDE] = mode_q[modeIdx].widePwmEn;
      rdData[`PCFG_BIT_PWMEN] = mode_q[modeIdx].pwmEn;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_ovf_sets_flag: assert property (
    ovfPulse |=> cfg_q.cycleOvfFlag)
    else $error("overflow did not set flag");

  a_flag_holds: assert property (
    cfg_q.cycleOvfFlag && !wrCfg |=> cfg_q.cycleOvfFlag)
    else $error("flag cleared without software write");

  a_nine_bit_ovf: assert property (
    counterTick && cfg_q.cycleLengthSel == pcfg_pkg::LEN9 &&
    counterValue[8:0] == 9'h1ff |-> ovfPulse)
    else $error("9-bit overflow missed");

  a_eight_bit_only: assert property (
    cfg_q.cycleLengthSel == pcfg_pkg::LEN8 && counterTick &&
    counterValue[7:0] != 8'hff |-> !ovfPulse)
    else $error("8-bit overflow at wrong count");

  a_irq_enabled: assert property (
    cfg_q.cycleOvfFlag && cfg_q.cycleOvfIrqEn |=> irq)
    else $error("enabled flag gave no interrupt");

  a_irq_masked: assert property (
    !cfg_q.cycleOvfIrqEn && !(|(status_q & mask_q)) |=> !irq)
    else $error("interrupt without enabled source");

  a_unused_zero: assert property (
    read && waitReq_q && address == `PCFG_OFF_CONFIG
    |=> readdata[4:2] == 3'b000)
    else $error("unused config bits read nonzero");

  a_reload_route: assert property (
    wrCcAny && cfg_q.reloadRegSelect && !ovfPulse
    |=> $stable(ccValue))
    else $error("shadow write reached compare word");

  a_reload_apply: assert property (
    ovfPulse && reloadUse[0] && !(wrCcAny && ccIdx == 3'h0)
    |=> ccValue[0] == $past(reloadWord[0]))
    else $error("reload not applied to channel 0");

  a_wide_ignores: assert property (
    ovfPulse && (mode_q[0].widePwmEn ||
    cfg_q.cycleLengthSel == pcfg_pkg::LEN8) && !wrCcAny
    |=> $stable(ccValue[0]))
    else $error("reload touched channel outside 9-11 bit PWM");

  a_wait_answer: assert property (
    (read || write) && waitReq_q |=> !waitReq_q ##1 waitReq_q)
    else $error("bus answer timing broken");

  a_ten_bit_ovf: assert property (
    counterTick && cfg_q.cycleLengthSel == pcfg_pkg::LEN10 &&
    counterValue[9:0] == 10'h3ff |-> ovfPulse)
    else $error("10-bit overflow missed");

  a_eleven_bit_ovf: assert property (
    counterTick && cfg_q.cycleLengthSel == pcfg_pkg::LEN11 &&
    counterValue[10:0] == 11'h7ff |-> ovfPulse)
    else $error("11-bit overflow missed");

  a_status_sticky: assert property (
    status_q[`PCFG_EVT_OVF] && !wrStatus |=> status_q[`PCFG_EVT_OVF])
    else $error("overflow event cleared without write");

  c_reload_done: cover property (ovfPulse && (|reloadUse));
  c_irq_rise: cover property (!irq ##1 irq);
  c_shadow_write: cover property (wrReload);
  c_eleven_ovf: cover property (
    ovfPulse && cfg_q.cycleLengthSel == pcfg_pkg::LEN11);
  c_ten_ovf: cover property (
    ovfPulse && cfg_q.cycleLengthSel == pcfg_pkg::LEN10);

endmodule

//--- verification/pcfg_top_test.sv
`timescale 1ns/1ps
`include "pcfg_cfg.svh"
module pcfg_top_test;
  // Clock and reset
  logic mclk;
  logic rst;
  // Register bus
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  // Counter and channel side
  logic [15:0] counterValue;
  logic counterTick;
  logic [`PCFG_CH_COUNT-1:0][15:0] ccValue;
  pcfg_pkg::pcfg_mode_type [`PCFG_CH_COUNT-1:0] chMode;
  pcfg_pkg::pcfg_len_type cycleLen;
  logic irq;
  int nFail;
  int samplesChecked;
  logic [31:0] rd;
  logic [15:0] mask;

  pcfg_top i_pcfg_top (
    .mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .counterValue(counterValue), .counterTick(counterTick),
    .ccValue(ccValue), .chMode(chMode), .cycleLen(cycleLen), .irq(irq)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Free-running 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One access, held until waitrequest is seen low at an edge;
  // a hang is left to the watchdog. Returns just after that edge,
  // so register outputs written there have settled
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= {24'h000000, d};
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    #1;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, e);
  endtask

  // Single counter step; flag is visible once this returns
  task automatic tick(input logic [15:0] v);
    @(posedge mclk);
    counterValue <= v;
    counterTick <= 1'b1;
    @(posedge mclk);
    counterTick <= 1'b0;
    #1;
  endtask

  // Irq trails its cause by a registered stage, so wait two edges
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk);
    #1;
    check({31'h0, irq}, {31'h0, e});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    check({31'h0, waitrequest}, 32'h1);
    check({31'h0, irq}, 32'h0);
    expect_reg(`PCFG_OFF_CONFIG, 32'h0);
    expect_reg(8'hfc, 32'h0);
  endtask

  // Spare bits stay zero, every length code lands on the output
  task automatic t_length;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `PCFG_OFF_CONFIG, {6'h07, c[1:0]});
      expect_reg(`PCFG_OFF_CONFIG, {30'h0, c[1:0]});
      check({30'h0, cycleLen}, {30'h0, c[1:0]});
    end
  endtask

  // One bit short of the selected carry must not set the flag
  task automatic t_overflow;
    for (int c = 0; c < 4; c++) begin
      mask = (16'h0100 << c) - 16'h0001;
      bus(1'b1, `PCFG_OFF_CONFIG, {6'h00, c[1:0]});
      tick(mask >> 1);
      expect_reg(`PCFG_OFF_CONFIG, {30'h0, c[1:0]});
      tick(mask);
      expect_reg(`PCFG_OFF_CONFIG, {26'h0, 4'h8, c[1:0]});
      tick(16'h0000);
      expect_reg(`PCFG_OFF_CONFIG, {26'h0, 4'h8, c[1:0]});
      bus(1'b1, `PCFG_OFF_CONFIG, {6'h00, c[1:0]});
      expect_reg(`PCFG_OFF_CONFIG, {30'h0, c[1:0]});
    end
    bus(1'b1, `PCFG_OFF_STATUS, 8'h03);
  endtask

  task automatic t_irq;
    bus(1'b1, `PCFG_OFF_CONFIG, 8'h60);
    expect_reg(`PCFG_OFF_CONFIG, 32'h60);
    irq_is(1'b1);
    bus(1'b1, `PCFG_OFF_CONFIG, 8'h40);
    irq_is(1'b0);
    // Flag set with its enable off: no request
    bus(1'b1, `PCFG_OFF_CONFIG, 8'h00);
    tick(16'h00ff);
    irq_is(1'b0);
    expect_reg(`PCFG_OFF_STATUS, 32'h1);
    bus(1'b1, `PCFG_OFF_MASK, 8'h01);
    irq_is(1'b1);
    bus(1'b1, `PCFG_OFF_STATUS, 8'h01);
    irq_is(1'b0);
    bus(1'b1, `PCFG_OFF_MASK, 8'h00);
    bus(1'b1, `PCFG_OFF_CONFIG, 8'h00);
  endtask

  // Channel 0 plain PWM, channel 1 wide PWM
  task automatic t_reload;
    bus(1'b1, `PCFG_OFF_CC_BASE, 8'h34);
    bus(1'b1, `PCFG_OFF_CC_BASE + 8'h04, 8'h12);
    check({16'h0, ccValue[0]}, 32'h1234);
    bus(1'b1, `PCFG_OFF_MODE_BASE, 8'h02);
    bus(1'b1, `PCFG_OFF_MODE_BASE + 8'h04, 8'h82);
    expect_reg(`PCFG_OFF_MODE_BASE + 8'h04, 32'h82);
    check({30'h0, chMode[1]}, 32'h3);
    bus(1'b1, `PCFG_OFF_CONFIG, 8'h81);
    bus(1'b1, `PCFG_OFF_CC_BASE, 8'hcd);
    bus(1'b1, `PCFG_OFF_CC_BASE + 8'h04, 8'hab);
    bus(1'b1, `PCFG_OFF_CC_BASE + 8'h08, 8'h66);
    bus(1'b1, `PCFG_OFF_CC_BASE + 8'h0c, 8'h55);
    check({16'h0, ccValue[0]}, 32'h1234);
    expect_reg(`PCFG_OFF_CC_BASE, 32'hcd);
    tick(16'h01ff);
    check({16'h0, ccValue[0]}, 32'habcd);
    check({16'h0, ccValue[1]}, 32'h0000);
    // Eight-bit cycle: shadow words must stay out of the way
    bus(1'b1, `PCFG_OFF_CONFIG, 8'h00);
    bus(1'b1, `PCFG_OFF_CC_BASE, 8'h00);
    tick(16'h00ff);
    check({16'h0, ccValue[0]}, 32'hab00);
  endtask

  // Write with the low byte lane off must be ignored
  task automatic t_lanes;
    @(posedge mclk);
    byteenable <= 4'h0;
    bus(1'b1, `PCFG_OFF_MASK, 8'h03);
    @(posedge mclk);
    byteenable <= 4'h1;
    expect_reg(`PCFG_OFF_MASK, 32'h0);
  endtask

  // Counter readback, then a reset in mid-run clears the registers
  task automatic t_midreset;
    expect_reg(`PCFG_OFF_COUNT, 32'h00ff);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check({16'h0, ccValue[0]}, 32'h0);
    check({30'h0, chMode[1]}, 32'h0);
    check({30'h0, cycleLen}, 32'h0);
    check({31'h0, irq}, 32'h0);
    expect_reg(`PCFG_OFF_CC_BASE + 8'h04, 32'h0);
  endtask

  // ****************************************************************
  // Sequence and verdict
  // ****************************************************************
  task automatic summarize;
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; allow ample margin
  initial begin
    #(20000 * 4);
    nFail++;
    summarize();
  end

  // Inputs quiet at time zero, reset held for ten cycles
  initial begin
    nFail = 0;
    samplesChecked = 0;
    rst = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h1;
    counterValue = 16'h0000;
    counterTick = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_length();
    t_overflow();
    t_irq();
    t_reload();
    t_lanes();
    t_midreset();
    summarize();
  end
endmodule
